// ---- verilog/flash_front_pkg.sv ----
// Purpose: shared constants and types of the serial flash front end
// Assumes: one system clock, link pins sampled through synchronisers
// Notes: opcode values are the device instruction codes
//
// Functional notes
// - three protocols: single, dual, quad lines
// - protocol picked from volatile or nonvolatile bits
// - dual/quad carry every phase on 2/4 lines
// - all bits move most significant first
// - inputs latched on serial clock rising edges
// - opcode on line zero, lines 0-1, lines 0-3
// - opcode byte then address, data, both, none
// - in-place mode accepts only reads and exit
// - in-place read: address, dummy clocks, data
// - array and 64-byte one-time area accessible
// - program or erase may suspend and resume
// - 4K subsectors, sixteen per 64K sector
// - reads may end anywhere; outputs released
`default_nettype none
package flash_front_pkg;
  typedef enum logic [1:0] {proto_single, proto_dual, proto_quad} proto_type;
  typedef enum logic [2:0] {
    st_idle, st_opcode, st_addr, st_dummy, st_data_in, st_data_out, st_done
  } state_type;
  typedef enum logic [3:0] {
    kind_unknown, kind_read_array, kind_read_otp, kind_read_reg,
    kind_program, kind_program_otp, kind_erase_sub, kind_erase_sector,
    kind_erase_bulk, kind_suspend, kind_resume, kind_write_ctl
  } kind_type;
  // decoded command handed to the memory core
  typedef struct packed {
    kind_type kind;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [11:0] subsector;
    logic [7:0] sector;
  } cmd_info_type;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_READ_SFDP = 8'h5A;
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] OP_READ_OTP = 8'h4B;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_DUAL_PROGRAM = 8'hA2;
  localparam logic [7:0] OP_DUAL_EXT_PROGRAM = 8'hD2;
  localparam logic [7:0] OP_QUAD_PROGRAM = 8'h32;
  localparam logic [7:0] OP_QUAD_EXT_PROGRAM = 8'h12;
  localparam logic [7:0] OP_PROGRAM_OTP = 8'h42;
  localparam logic [7:0] OP_ERASE_SUB = 8'h20;
  localparam logic [7:0] OP_ERASE_SECTOR = 8'hD8;
  localparam logic [7:0] OP_ERASE_BULK = 8'hC7;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [4:0] OPCODE_BITS = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] DUMMY_FAST = 5'h08;
  localparam logic [4:0] DUMMY_QUAD_IO = 5'h0A;
  localparam int SUBSECTOR_SHIFT = 12;
  localparam int SECTOR_SHIFT = 16;
  localparam int OTP_BYTES = 64;

  // opcode to command kind; codes outside the table fall to kind_unknown
  function automatic kind_type decode(input logic [7:0] op);
    case (op)
      OP_READ, OP_FAST_READ, OP_DUAL_OUT_READ, OP_DUAL_IO_READ, OP_QUAD_OUT_READ,
      OP_QUAD_IO_READ: decode = kind_read_array;
      OP_READ_OTP: decode = kind_read_otp;
      OP_READ_STATUS, OP_READ_SFDP: decode = kind_read_reg;
      OP_PROGRAM, OP_DUAL_PROGRAM, OP_DUAL_EXT_PROGRAM, OP_QUAD_PROGRAM,
      OP_QUAD_EXT_PROGRAM: decode = kind_program;
      OP_PROGRAM_OTP: decode = kind_program_otp;
      OP_ERASE_SUB: decode = kind_erase_sub;
      OP_ERASE_SECTOR: decode = kind_erase_sector;
      OP_ERASE_BULK: decode = kind_erase_bulk;
      OP_SUSPEND: decode = kind_suspend;
      OP_RESUME: decode = kind_resume;
      OP_WRITE_ENABLE, OP_WRITE_DISABLE: decode = kind_write_ctl;
      default: decode = kind_unknown;
    endcase
  endfunction

  // dummy clocks that follow the address, per opcode
  function automatic logic [4:0] dummy_of(input logic [7:0] op);
    case (op)
      OP_QUAD_IO_READ: dummy_of = DUMMY_QUAD_IO;
      OP_FAST_READ, OP_READ_SFDP, OP_DUAL_OUT_READ, OP_DUAL_IO_READ, OP_QUAD_OUT_READ,
      OP_READ_OTP: dummy_of = DUMMY_FAST;
      default: dummy_of = 5'h00;
    endcase
  endfunction

  // phase after the header, from the decoded kind
  function automatic state_type after_hdr(input kind_type k, input logic [4:0] dummy);
    if (k inside {kind_read_array, kind_read_otp, kind_read_reg}) begin
      after_hdr = (dummy != 5'h00) ? st_dummy : st_data_out;
    end else if (k inside {kind_program, kind_program_otp}) begin
      after_hdr = st_data_in;
    end else begin
      after_hdr = st_done;
    end
  endfunction
endpackage
`default_nettype wire

// ---- verilog/flash_sync.sv ----
// Purpose: two-stage synchroniser for pins from the link
// Assumes: inputs asynchronous to clk
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module flash_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins in, synchronised out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // idle value is all ones so select reads inactive after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '1;
      sync_out <= '1;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/flash_front.sv ----
// Purpose: framing of instructions, addresses and data on the serial link
// Assumes: serial clock much slower than clk (at least 8 clk per period)
// Notes: memory core sits behind the cmd/rd/wr ports
`timescale 1ns/10ps
`default_nettype none
module flash_front (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link pins
  input wire logic serial_clk,
  input wire logic select_n,
  input wire logic [3:0] data_line_in,
  output logic [3:0] data_line_out,
  output logic [3:0] data_line_oe,
  // configuration levels
  input wire flash_front_pkg::proto_type proto_nv,
  input wire flash_front_pkg::proto_type proto_volatile,
  input wire logic proto_volatile_set,
  input wire logic in_place_request,
  input wire logic [4:0] in_place_dummy,
  // core side
  output flash_front_pkg::cmd_info_type cmd_info,
  output logic cmd_start,
  output logic cmd_commit,
  output logic cmd_reject,
  output logic wr_valid,
  output logic [7:0] wr_byte,
  input wire logic [7:0] rd_data,
  output logic rd_req,
  output logic execute_in_place_mode,
  output flash_front_pkg::proto_type proto
);
  logic [5:0] pins;
  logic sclk_d, cs_d, rise, fall, frame_start, frame_end;
  flash_front_pkg::state_type state;
  logic [23:0] sh;
  logic [4:0] cnt, dummy_target;
  logic [2:0] bit_mod;
  logic [3:0] lanes, out_left;
  logic [7:0] out_sh;
  logic hdr_done, exit_pending;
  logic [23:0] nxt_sh;
  logic [4:0] nxt_cnt;

  flash_sync #(.WIDTH(6)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({serial_clk, select_n, data_line_in}),
    .sync_out(pins)
  );

  // edges of the sampled serial clock and select
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_d <= 1'b1; // same level the synchroniser resets to: no false edge
      cs_d <= 1'b1;
    end else begin
      sclk_d <= pins[5];
      cs_d <= pins[4];
    end
  end
  assign rise = pins[5] & ~sclk_d & ~pins[4];
  assign fall = ~pins[5] & sclk_d & ~pins[4];
  assign frame_start = cs_d & ~pins[4];
  assign frame_end = ~cs_d & pins[4];

  // lines per clock; opcode lines follow the protocol
  assign lanes = (proto == flash_front_pkg::proto_quad) ? 4'h4 :
                 (proto == flash_front_pkg::proto_dual) ? 4'h2 : 4'h1;
  assign nxt_cnt = cnt + {1'b0, lanes};

  // msb first: new bits enter at the bottom
  always_comb begin
    case (proto)
      flash_front_pkg::proto_quad: nxt_sh = {sh[19:0], pins[3:0]};
      flash_front_pkg::proto_dual: nxt_sh = {sh[21:0], pins[1:0]};
      default: nxt_sh = {sh[22:0], pins[0]};
    endcase
  end

  function automatic logic has_addr(input flash_front_pkg::kind_type k,
                                    input logic [7:0] op);
    has_addr = (k inside {flash_front_pkg::kind_read_array, flash_front_pkg::kind_read_otp,
                flash_front_pkg::kind_program, flash_front_pkg::kind_program_otp,
                flash_front_pkg::kind_erase_sub, flash_front_pkg::kind_erase_sector}) ||
               (op == flash_front_pkg::OP_READ_SFDP);
  endfunction

  function automatic logic is_modify(input flash_front_pkg::kind_type k);
    is_modify = k inside {flash_front_pkg::kind_program, flash_front_pkg::kind_program_otp,
                flash_front_pkg::kind_erase_sub, flash_front_pkg::kind_erase_sector,
                flash_front_pkg::kind_erase_bulk, flash_front_pkg::kind_write_ctl};
  endfunction

  // protocol is taken at frame start so it never changes mid-frame
  always_ff @(posedge clk) begin
    if (rst) begin
      proto <= flash_front_pkg::proto_single;
    end else if (frame_start) begin
      proto <= proto_volatile_set ? proto_volatile : proto_nv;
    end
  end

  // frame sequencer: opcode, address, dummy, data
  always_ff @(posedge clk) begin
    if (rst || frame_end) begin
      state <= flash_front_pkg::st_idle;
      cnt <= 5'h00;
      sh <= 24'h00_0000;
      hdr_done <= 1'b0;
      cmd_start <= 1'b0;
      wr_valid <= 1'b0;
      if (rst) begin
        cmd_info <= '0;
        dummy_target <= 5'h00;
        wr_byte <= 8'h00;
      end
    end else begin
      cmd_start <= 1'b0;
      wr_valid <= 1'b0;
      if (frame_start) begin
        cnt <= 5'h00;
        if (execute_in_place_mode) begin
          // no opcode: straight into the address
          state <= flash_front_pkg::st_addr;
          cmd_info.kind <= flash_front_pkg::kind_read_array;
          cmd_info.opcode <= 8'h00;
          dummy_target <= in_place_dummy;
        end else begin
          state <= flash_front_pkg::st_opcode;
        end
      end else if (rise) begin
        case (state)
          flash_front_pkg::st_opcode: begin
            sh <= nxt_sh;
            cnt <= nxt_cnt;
            if (nxt_cnt == flash_front_pkg::OPCODE_BITS) begin
              cnt <= 5'h00;
              cmd_info.opcode <= nxt_sh[7:0];
              cmd_info.kind <= flash_front_pkg::decode(nxt_sh[7:0]);
              dummy_target <= flash_front_pkg::dummy_of(nxt_sh[7:0]);
              if (has_addr(flash_front_pkg::decode(nxt_sh[7:0]), nxt_sh[7:0])) begin
                state <= flash_front_pkg::st_addr;
              end else begin
                hdr_done <= 1'b1;
                cmd_start <= 1'b1;
                state <= flash_front_pkg::after_hdr(flash_front_pkg::decode(nxt_sh[7:0]), 5'h00);
              end
            end
          end
          flash_front_pkg::st_addr: begin
            sh <= nxt_sh;
            cnt <= nxt_cnt;
            if (nxt_cnt == flash_front_pkg::ADDR_BITS) begin
              cnt <= 5'h00;
              cmd_info.addr <= nxt_sh;
              cmd_info.subsector <= nxt_sh[23:flash_front_pkg::SUBSECTOR_SHIFT];
              cmd_info.sector <= nxt_sh[23:flash_front_pkg::SECTOR_SHIFT];
              hdr_done <= 1'b1;
              cmd_start <= 1'b1;
              state <= flash_front_pkg::after_hdr(cmd_info.kind, dummy_target);
            end
          end
          flash_front_pkg::st_dummy: begin
            cnt <= cnt + 5'h01;
            if (cnt + 5'h01 >= dummy_target) begin
              state <= flash_front_pkg::st_data_out;
            end
          end
          flash_front_pkg::st_data_in: begin
            sh <= nxt_sh;
            cnt <= nxt_cnt;
            if (nxt_cnt == flash_front_pkg::BYTE_BITS) begin
              cnt <= 5'h00;
              wr_valid <= 1'b1;
              wr_byte <= nxt_sh[7:0];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // bits moved in the frame, modulo eight, for the byte-boundary check
  always_ff @(posedge clk) begin
    if (rst || frame_start) begin
      bit_mod <= 3'h0;
    end else if (rise) begin
      bit_mod <= bit_mod + lanes[2:0];
    end
  end

  // end of frame: modify commands run only on a whole byte
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_commit <= 1'b0;
      cmd_reject <= 1'b0;
    end else begin
      cmd_commit <= frame_end && hdr_done && is_modify(cmd_info.kind) &&
                    bit_mod == 3'h0;
      cmd_reject <= frame_end && hdr_done && is_modify(cmd_info.kind) &&
                    bit_mod != 3'h0;
    end
  end

  // in-place mode: entered at frame end after an array read when asked, left at frame end if line zero was high on the first dummy clock
  always_ff @(posedge clk) begin
    if (rst) begin
      execute_in_place_mode <= 1'b0;
      exit_pending <= 1'b0;
    end else if (frame_end) begin
      exit_pending <= 1'b0;
      if (execute_in_place_mode && exit_pending) begin
        execute_in_place_mode <= 1'b0;
      end else if (hdr_done && cmd_info.kind == flash_front_pkg::kind_read_array &&
                   in_place_request) begin
        execute_in_place_mode <= 1'b1;
      end
    end else if (rise && execute_in_place_mode && state == flash_front_pkg::st_dummy &&
                 cnt == 5'h00) begin
      exit_pending <= pins[0];
    end
  end

  // output shifting on falling edges; released as soon as select rises
  always_ff @(posedge clk) begin
    if (rst || state != flash_front_pkg::st_data_out || pins[4]) begin
      data_line_oe <= 4'h0;
      data_line_out <= 4'h0;
      out_left <= 4'h0;
      out_sh <= 8'h00;
      rd_req <= 1'b0;
    end else begin
      rd_req <= fall && out_left == 4'h0;
      if (fall) begin
        case (proto)
          flash_front_pkg::proto_quad: begin
            data_line_out <= (out_left == 4'h0) ? rd_data[7:4] : out_sh[7:4];
            data_line_oe <= 4'hF;
          end
          flash_front_pkg::proto_dual: begin
            data_line_out <= {2'h0, (out_left == 4'h0) ? rd_data[7:6] : out_sh[7:6]};
            data_line_oe <= 4'h3;
          end
          default: begin
            data_line_out <= {2'h0, (out_left == 4'h0) ? rd_data[7] : out_sh[7], 1'b0};
            data_line_oe <= 4'h2;
          end
        endcase
        out_sh <= ((out_left == 4'h0) ? rd_data : out_sh) << lanes;
        out_left <= ((out_left == 4'h0) ? 4'h8 : out_left) - lanes;
      end
    end
  end

  oe_release_a: assert property (@(posedge clk) disable iff (rst)
    frame_end |=> data_line_oe == 4'h0) else $error("outputs held after select");
  reset_count_a: assert property (@(posedge clk) disable iff (rst)
    frame_end |=> state == flash_front_pkg::st_idle && cnt == 5'h00)
    else $error("counters not cleared");
  in_place_read_a: assert property (@(posedge clk) disable iff (rst)
    cmd_start && execute_in_place_mode |-> cmd_info.kind == flash_front_pkg::kind_read_array &&
    cmd_info.opcode == 8'h00) else $error("non-read in place");
  sector_map_a: assert property (@(posedge clk) disable iff (rst)
    cmd_start && has_addr(cmd_info.kind, cmd_info.opcode) |->
    cmd_info.sector == cmd_info.subsector[11:4] && cmd_info.subsector == cmd_info.addr[23:12])
    else $error("bad sector map");
  boundary_a: assert property (@(posedge clk) disable iff (rst)
    cmd_reject |-> $past(bit_mod) != 3'h0 && !cmd_commit)
    else $error("reject on boundary");
  proto_hold_a: assert property (@(posedge clk) disable iff (rst)
    !frame_start |=> $stable(proto)) else $error("protocol moved mid frame");
  opcode_len_a: assert property (@(posedge clk) disable iff (rst)
    state == flash_front_pkg::st_opcode && rise && nxt_cnt == flash_front_pkg::OPCODE_BITS
    |=> cmd_info.opcode == $past(nxt_sh[7:0])) else $error("opcode capture");
  dummy_len_a: assert property (@(posedge clk) disable iff (rst)
    state == flash_front_pkg::st_dummy |-> cnt < dummy_target)
    else $error("dummy overrun");
  lane_width_a: assert property (@(posedge clk) disable iff (rst)
    data_line_oe != 4'h0 |-> data_line_oe == ((proto == flash_front_pkg::proto_quad) ? 4'hF :
    (proto == flash_front_pkg::proto_dual) ? 4'h3 : 4'h2)) else $error("wrong lanes");
  read_cov_c: cover property (@(posedge clk) disable iff (rst) rd_req ##[1:400] frame_end);
  commit_cov_c: cover property (@(posedge clk) disable iff (rst) cmd_commit);
  reject_cov_c: cover property (@(posedge clk) disable iff (rst) cmd_reject);
  in_place_cov_c: cover property (@(posedge clk) disable iff (rst)
    cmd_start && execute_in_place_mode);
endmodule
`default_nettype wire

// ---- verification/flash_host_model.sv ----
// Purpose: host bus controller model that drives the flash front end link
// Assumes: serial clock idles low, 80 ns period, data changes while low
// Notes: lines the host has released show the inverse of their last value
`timescale 1ns/10ps
`default_nettype none
module flash_host_model (
  // link pins towards the device
  output logic serial_clk,
  output logic select_n,
  output logic [3:0] line_in,
  // device output drivers
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_oe
);
  logic [3:0] drv;

  // wire level: the device wins where it drives, else the host value
  assign line_in = (dev_oe & dev_out) | (~dev_oe & drv);

  // idle pins at time zero
  initial begin
    serial_clk = 1'b0;
    select_n = 1'b1;
    drv = 4'h0;
  end

  // select low; the first rising edge follows half a period later
  task automatic frame_open();
    #40 select_n = 1'b0;
  endtask

  // shift nbits msb first, lanes bits per clock, msb on the highest lane
  task automatic send(input logic [31:0] val, input int nbits, input int lanes);
    for (int b = nbits - lanes; b >= 0; b -= lanes) begin
      drv = 4'(val >> b) & 4'((1 << lanes) - 1);
      #40 serial_clk = 1'b1;
      #40 serial_clk = 1'b0;
    end
  endtask

  // take one byte; single reads come on line one, wider ones on low lanes
  task automatic fetch(output logic [7:0] val, input int lanes);
    drv = ~drv; // released: never leave a stale level that could pass by luck
    val = 8'h00;
    for (int c = 0; c < 8 / lanes; c++) begin
      #40 serial_clk = 1'b1;
      if (lanes == 1) begin
        val = {val[6:0], line_in[1]};
      end else begin
        val = (val << lanes) | 8'(line_in & 4'((1 << lanes) - 1));
      end
      #40 serial_clk = 1'b0;
    end
  endtask

  // raise select with the clock low, then leave the device time to settle
  task automatic frame_close();
    #40 select_n = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

// ---- verification/serial_flash_instruction_framing_test.sv ----
// Purpose: self-checking bench of the serial flash front end
// Assumes: host model drives the link; core strobes counted here
// Notes: rd_data steps by one on every consumed byte
`timescale 1ns/10ps
`default_nettype none
module serial_flash_instruction_framing_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic serial_clk, select_n;
  logic [3:0] data_line_in, data_line_out, data_line_oe;
  flash_front_pkg::proto_type proto_nv = flash_front_pkg::proto_single;
  flash_front_pkg::proto_type proto_volatile = flash_front_pkg::proto_single;
  flash_front_pkg::proto_type proto;
  logic proto_volatile_set = 1'b0;
  logic in_place_request = 1'b0;
  logic [4:0] in_place_dummy = 5'h08;
  flash_front_pkg::cmd_info_type cmd_info;
  logic cmd_start, cmd_commit, cmd_reject, wr_valid, rd_req, execute_in_place_mode;
  logic [7:0] wr_byte, last_wr;
  logic [7:0] rd_data = 8'hA5;
  logic [7:0] base_d;
  int starts = 0, commits = 0, rejects = 0, writes = 0;
  int base_s, base_c, base_r, base_w;
  int err_count = 0;
  int check_count = 0;

  flash_front flash_front_i (.clk(clk), .rst(rst), .serial_clk(serial_clk),
    .select_n(select_n), .data_line_in(data_line_in), .data_line_out(data_line_out),
    .data_line_oe(data_line_oe), .proto_nv(proto_nv), .proto_volatile(proto_volatile),
    .proto_volatile_set(proto_volatile_set), .in_place_request(in_place_request),
    .in_place_dummy(in_place_dummy), .cmd_info(cmd_info), .cmd_start(cmd_start),
    .cmd_commit(cmd_commit), .cmd_reject(cmd_reject), .wr_valid(wr_valid),
    .wr_byte(wr_byte), .rd_data(rd_data), .rd_req(rd_req),
    .execute_in_place_mode(execute_in_place_mode), .proto(proto));

  flash_host_model host_i (.serial_clk(serial_clk), .select_n(select_n),
    .line_in(data_line_in), .dev_out(data_line_out), .dev_oe(data_line_oe));

  always #2 clk = ~clk;

  // core side: count one-cycle strobes, feed the next read byte late
  always @(posedge clk) begin
    if (cmd_start === 1'b1) starts <= starts + 1;
    if (cmd_commit === 1'b1) commits <= commits + 1;
    if (cmd_reject === 1'b1) rejects <= rejects + 1;
    if (wr_valid === 1'b1) begin
      writes <= writes + 1;
      last_wr <= wr_byte;
    end
    if (rd_req === 1'b1) rd_data <= #1 rd_data + 8'h01;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // snapshot counters so each test judges only its own strobes
  task automatic mark();
    base_s = starts;
    base_c = commits;
    base_r = rejects;
    base_w = writes;
    base_d = rd_data;
  endtask

  task automatic cfg(input flash_front_pkg::proto_type nv,
                     input flash_front_pkg::proto_type vol, input logic vset);
    @(posedge clk);
    #1;
    proto_nv = nv;
    proto_volatile = vol;
    proto_volatile_set = vset;
  endtask

  task automatic test_single_read();
    logic [7:0] b0, b1;
    mark();
    host_i.frame_open();
    host_i.send(32'h0000_0003, 8, 1);
    host_i.send(32'h001C_F123, 24, 1);
    host_i.fetch(b0, 1);
    check(data_line_oe, 4'h2);
    host_i.fetch(b1, 1);
    host_i.frame_close();
    check(b0, base_d);
    check(b1, base_d + 8'h01);
    check(data_line_oe, 4'h0);
    check(cmd_info.kind, flash_front_pkg::kind_read_array);
    check(cmd_info.addr, 24'h1C_F123);
    check(cmd_info.subsector, 12'h1CF);
    check(cmd_info.sector, 8'h1C);
    check(starts - base_s, 1);
    check(commits - base_c, 0);
    $display("single read done");
  endtask

  task automatic test_in_place();
    logic [7:0] b0;
    cfg(flash_front_pkg::proto_quad, flash_front_pkg::proto_single, 1'b0);
    in_place_request = 1'b1;
    mark();
    host_i.frame_open();
    host_i.send(32'h0000_00EB, 8, 4);
    host_i.send(32'h002A_5000, 24, 4);
    host_i.send(32'h0000_0000, 40, 4);
    host_i.fetch(b0, 4);
    check(data_line_oe, 4'hF);
    host_i.frame_close();
    in_place_request = 1'b0;
    check(b0, base_d);
    check(proto, flash_front_pkg::proto_quad);
    check(cmd_info.opcode, 8'hEB);
    check(execute_in_place_mode, 1'b1);
    mark();
    host_i.frame_open();
    host_i.send(32'h0012_3456, 24, 4);
    host_i.send(32'h0000_0000, 32, 4);
    host_i.fetch(b0, 4);
    host_i.frame_close();
    check(b0, base_d);
    check(cmd_info.addr, 24'h12_3456);
    check(starts - base_s, 1);
    check(execute_in_place_mode, 1'b1);
    // line zero high on the first dummy clock asks to leave the mode
    mark();
    host_i.frame_open();
    host_i.send(32'h0002_0000, 24, 4);
    host_i.send(32'h1000_0000, 32, 4);
    host_i.fetch(b0, 4);
    host_i.frame_close();
    check(execute_in_place_mode, 1'b0);
    check(commits - base_c, 0);
    $display("in place done");
  endtask

  task automatic test_dual_program();
    logic [7:0] b0;
    cfg(flash_front_pkg::proto_single, flash_front_pkg::proto_dual, 1'b1);
    mark();
    host_i.frame_open();
    host_i.send(32'h0000_0002, 8, 2);
    host_i.send(32'h000F_FFFF, 24, 2);
    host_i.send(32'h0000_3CC3, 16, 2);
    host_i.frame_close();
    check(proto, flash_front_pkg::proto_dual);
    check(cmd_info.kind, flash_front_pkg::kind_program);
    check(cmd_info.subsector, 12'h0FF);
    check(cmd_info.sector, 8'h0F);
    check(writes - base_w, 2);
    check(last_wr, 8'hC3);
    check(commits - base_c, 1);
    // dual read: opcode on two lines, eight dummy clocks, data on two lines
    mark();
    host_i.frame_open();
    host_i.send(32'h0000_00BB, 8, 2);
    host_i.send(32'h0004_2000, 24, 2);
    host_i.send(32'h0000_0000, 16, 2);
    host_i.fetch(b0, 2);
    check(data_line_oe, 4'h3);
    host_i.frame_close();
    check(b0, base_d);
    check(cmd_info.kind, flash_front_pkg::kind_read_array);
    check(cmd_info.subsector, 12'h042);
    check(cmd_info.sector, 8'h04);
    check(commits - base_c, 0);
    $display("dual program done");
  endtask

  // header-only and address-only commands, nine opcodes across eight kinds
  task automatic test_command_table();
    logic [7:0] ops [9] = '{8'h06, 8'h04, 8'h75, 8'h7A, 8'hC7, 8'h20, 8'hD8, 8'h42, 8'h4B};
    flash_front_pkg::kind_type kinds [9] = '{flash_front_pkg::kind_write_ctl,
      flash_front_pkg::kind_write_ctl, flash_front_pkg::kind_suspend,
      flash_front_pkg::kind_resume, flash_front_pkg::kind_erase_bulk,
      flash_front_pkg::kind_erase_sub, flash_front_pkg::kind_erase_sector,
      flash_front_pkg::kind_program_otp, flash_front_pkg::kind_read_otp};
    logic [8:0] with_addr = 9'b1_1110_0000;
    logic [8:0] commits_exp = 9'b0_1111_0011;
    cfg(flash_front_pkg::proto_single, flash_front_pkg::proto_single, 1'b0);
    for (int i = 0; i < 9; i++) begin
      mark();
      host_i.frame_open();
      host_i.send(32'(ops[i]), 8, 1);
      if (with_addr[i]) host_i.send(32'h0001_0000, 24, 1);
      host_i.frame_close();
      check(cmd_info.kind, kinds[i]);
      check(starts - base_s, 1);
      check(commits - base_c, 32'(commits_exp[i]));
    end
    check(cmd_info.subsector, 12'h010);
    $display("command table done");
  endtask

  task automatic test_reject();
    mark();
    host_i.frame_open();
    host_i.send(32'h0000_0020, 8, 1);
    host_i.send(32'h0001_0000, 25, 1);
    host_i.frame_close();
    check(rejects - base_r, 1);
    check(commits - base_c, 0);
    $display("reject done");
  endtask

  // watchdog: all frames take well under this span
  initial begin
    #300000;
    err_count++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    #1; // link pins then move 1 ns after clk edges, never on them
    test_single_read();
    test_in_place();
    test_dual_program();
    test_command_table();
    test_reject();
    close_out();
  end
endmodule
`default_nettype wire
